/* hdl/gppc_filter.sv */
// Per-pin input synchroniser and short-pulse noise filter.
// Assumes an asynchronous pin level; runs on the system clock.
`timescale 1ns/1ps
module gppc_filter #(
  parameter int CYCLES = gppc_pkg::FILTER_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin level and filtered result
  input wire logic pin_i,
  output logic level_o
);
  logic s1, s2, s3;
  logic [gppc_pkg::FILTER_CNT_W-1:0] cnt;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Level must stand past the filter width before it is passed on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= '0;
      level_o <= 1'b0;
    end
    else if (s2 != s3 || s3 == level_o)
      cnt <= '0;
    else if (cnt >= gppc_pkg::FILTER_CNT_W'(CYCLES))
    begin
      level_o <= s3;
      cnt <= '0;
    end
    else
      cnt <= cnt + 1'b1;
  end
endmodule

/* hdl/gppc_pkg.sv */
// Package for the general port pin control block: register map, reset values, timing.
// Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
package gppc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_DATA = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FUNC_SEL1 = 8'h08;
  localparam logic [7:0] OFS_FUNC_SEL2 = 8'h0c;
  localparam logic [7:0] OFS_OPEN_DRAIN = 8'h10;
  localparam logic [7:0] OFS_PULLUP = 8'h14;
  localparam logic [7:0] OFS_PULLDOWN = 8'h18;
  localparam logic [7:0] OFS_INPUT_ENABLE = 8'h1c;
  localparam logic [7:0] OFS_STANDBY_CTRL = 8'h20;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int STBY_STOP_BIT = 0;
  localparam int STBY_DRIVE_BIT = 1;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 20000;
  localparam int FILTER_WIDTH_NS = 30;
  localparam int FILTER_CYCLES = ((FILTER_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
    (FILTER_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILTER_CNT_W = 4;
endpackage

/* hdl/gppc_port.sv */
// General port pin control: one port of pins with AXI4-Lite registers.
// Notes on behaviour
// - Data register sets pin output value; reads return the pin levels, zero where the input is gated off.
// - Output-enable register drives pins; input enabling lives in its own register.
// - A function-select bit at one routes the peripheral; all zero means general pin.
// - Open-drain bit at one removes the high drive of the pin.
// - Pull-up register switches each pin's pull-up.
// - Pull-down register switches each pin's pull-down.
// - Input-enable register resets to all inputs disabled.
// - STOP with drive enable one keeps enables per their bits.
// - STOP with drive enable zero disables ordinary pins; exception pins unaffected.
// - In STOP, valid-gated outputs drive only while their data is valid.
// - General and non-exception function pins follow drive enable in STOP; here any EXCEPT_MASK pin is exempt, general or not.
// - Filtered pins reject pulses shorter than about the filter width.
// - After reset all pins are general with every enable off.
// - Outside STOP, interrupt input follows input enable regardless of function.
// Assumes an AXI4-Lite master that keeps one write and one read in flight.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module gppc_port #(
  parameter int WIDTH = 8,
  parameter logic [7:0] FILTER_MASK = 8'hff,
  parameter logic [7:0] EXCEPT_MASK = 8'h00,
  parameter logic [7:0] VALID_GATED_MASK = 8'h00
)
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // AXI4-Lite write
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Pins
  input wire logic [WIDTH-1:0] PIN_I,
  output logic [WIDTH-1:0] PIN_O,
  output logic [WIDTH-1:0] PIN_OE_O,
  output logic [WIDTH-1:0] PULLUP_O,
  output logic [WIDTH-1:0] PULLDOWN_O,
  // Peripheral functions
  input wire logic [WIDTH-1:0] FUNC1_OUT_I,
  input wire logic [WIDTH-1:0] FUNC1_OE_I,
  input wire logic [WIDTH-1:0] FUNC2_OUT_I,
  input wire logic [WIDTH-1:0] FUNC2_OE_I,
  input wire logic [WIDTH-1:0] FUNC_VALID_I,
  output logic [WIDTH-1:0] FUNC_IN_O,
  output logic [WIDTH-1:0] EXT_INT_O
);
  logic [WIDTH-1:0] pin_data_reg, output_enable_reg, open_drain_reg;
  logic [WIDTH-1:0] pullup_enable_reg, pulldown_enable_reg, input_enable_reg;
  logic [WIDTH-1:0] function_select_reg1, function_select_reg2;
  logic [1:0] standby_control_reg;
  logic [WIDTH-1:0] pin_level, in_gate, out_gate, drv_val, drv_en;
  logic stop_mode, standby_drive_enable;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  default clocking gppc_cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  assign stop_mode = standby_control_reg[gppc_pkg::STBY_STOP_BIT];
  assign standby_drive_enable = standby_control_reg[gppc_pkg::STBY_DRIVE_BIT];

  // ----------------------------------------------------------------
  // Input conditioning per pin
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < WIDTH; gi++)
  begin : g_pin
    if (FILTER_MASK[gi])
    begin : g_filt
      gppc_filter u_filter (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .pin_i(PIN_I[gi]),
        .level_o(pin_level[gi])
      );
    end
    else
    begin : g_sync
      logic s1, s2, s3, lvl;
      always_ff @(posedge SYS_CLK_I)
      begin
        if (RST_I)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lvl <= 1'b0;
        end
        else
        begin
          s1 <= PIN_I[gi];
          s2 <= s1;
          s3 <= s2;
          lvl <= (s2 == s3) ? s3 : lvl;
        end
      end
      assign pin_level[gi] = lvl;
    end
  end

  // ----------------------------------------------------------------
  // STOP gating and pin drive
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      in_gate[i] = input_enable_reg[i];
      out_gate[i] = 1'b1;
      if (stop_mode && !standby_drive_enable && !EXCEPT_MASK[i])
      begin
        in_gate[i] = 1'b0;
        out_gate[i] = 1'b0;
      end
      if (stop_mode && VALID_GATED_MASK[i])
        out_gate[i] = FUNC_VALID_I[i];
      if (function_select_reg1[i])
      begin
        drv_val[i] = FUNC1_OUT_I[i];
        drv_en[i] = FUNC1_OE_I[i] & output_enable_reg[i];
      end
      else if (function_select_reg2[i])
      begin
        drv_val[i] = FUNC2_OUT_I[i];
        drv_en[i] = FUNC2_OE_I[i] & output_enable_reg[i];
      end
      else
      begin
        drv_val[i] = pin_data_reg[i];
        drv_en[i] = output_enable_reg[i];
      end
    end
  end

  // Drive low whenever enabled, high only when not open-drain
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      PIN_O <= '0;
      PIN_OE_O <= '0;
      PULLUP_O <= '0;
      PULLDOWN_O <= '0;
      FUNC_IN_O <= '0;
      EXT_INT_O <= '0;
    end
    else
    begin
      PIN_O <= drv_val;
      PIN_OE_O <= drv_en & out_gate & ~(open_drain_reg & drv_val);
      PULLUP_O <= pullup_enable_reg;
      PULLDOWN_O <= pulldown_enable_reg;
      FUNC_IN_O <= pin_level & in_gate;
      EXT_INT_O <= pin_level & in_gate;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign AWREADY_O = !aw_held && !BVALID_O;
  assign WREADY_O = !w_held && !BVALID_O;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (aw_held && w_held)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end
    else
    begin
      if (AWVALID_I && AWREADY_O)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O)
      begin
        w_held <= 1'b1;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end
    end
  end

  // Register store; all reset to general pins with enables off
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      pin_data_reg <= '0;
      output_enable_reg <= '0;
      function_select_reg1 <= '0;
      function_select_reg2 <= '0;
      open_drain_reg <= '0;
      pullup_enable_reg <= '0;
      pulldown_enable_reg <= '0;
      input_enable_reg <= '0;
      standby_control_reg <= '0;
      BVALID_O <= 1'b0;
      BRESP_O <= gppc_pkg::RESP_OKAY;
    end
    else
    begin
      if (BVALID_O && BREADY_I)
        BVALID_O <= 1'b0;
      if (aw_held && w_held)
      begin
        BVALID_O <= 1'b1;
        BRESP_O <= gppc_pkg::RESP_OKAY;
        if (w_strb[0])
        begin
          case ({aw_addr[7:2], 2'b00})
            gppc_pkg::OFS_PIN_DATA: pin_data_reg <= w_data[WIDTH-1:0];
            gppc_pkg::OFS_OUTPUT_ENABLE: output_enable_reg <= w_data[WIDTH-1:0];
            gppc_pkg::OFS_FUNC_SEL1: function_select_reg1 <= w_data[WIDTH-1:0];
            gppc_pkg::OFS_FUNC_SEL2: function_select_reg2 <= w_data[WIDTH-1:0];
            gppc_pkg::OFS_OPEN_DRAIN: open_drain_reg <= w_data[WIDTH-1:0];
            gppc_pkg::OFS_PULLUP: pullup_enable_reg <= w_data[WIDTH-1:0];
            gppc_pkg::OFS_PULLDOWN: pulldown_enable_reg <= w_data[WIDTH-1:0];
            gppc_pkg::OFS_INPUT_ENABLE: input_enable_reg <= w_data[WIDTH-1:0];
            gppc_pkg::OFS_STANDBY_CTRL: standby_control_reg <= w_data[1:0];
            default: BRESP_O <= gppc_pkg::RESP_SLVERR;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign ARREADY_O = !RVALID_O;

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      RVALID_O <= 1'b0;
      RDATA_O <= gppc_pkg::RST_ZERO;
      RRESP_O <= gppc_pkg::RESP_OKAY;
    end
    else if (RVALID_O)
    begin
      if (RREADY_I)
        RVALID_O <= 1'b0;
    end
    else if (ARVALID_I)
    begin
      RVALID_O <= 1'b1;
      RRESP_O <= gppc_pkg::RESP_OKAY;
      RDATA_O <= gppc_pkg::RST_ZERO;
      case ({ARADDR_I[7:2], 2'b00})
        gppc_pkg::OFS_PIN_DATA: RDATA_O[WIDTH-1:0] <= pin_level & in_gate;
        gppc_pkg::OFS_OUTPUT_ENABLE: RDATA_O[WIDTH-1:0] <= output_enable_reg;
        gppc_pkg::OFS_FUNC_SEL1: RDATA_O[WIDTH-1:0] <= function_select_reg1;
        gppc_pkg::OFS_FUNC_SEL2: RDATA_O[WIDTH-1:0] <= function_select_reg2;
        gppc_pkg::OFS_OPEN_DRAIN: RDATA_O[WIDTH-1:0] <= open_drain_reg;
        gppc_pkg::OFS_PULLUP: RDATA_O[WIDTH-1:0] <= pullup_enable_reg;
        gppc_pkg::OFS_PULLDOWN: RDATA_O[WIDTH-1:0] <= pulldown_enable_reg;
        gppc_pkg::OFS_INPUT_ENABLE: RDATA_O[WIDTH-1:0] <= input_enable_reg;
        gppc_pkg::OFS_STANDBY_CTRL: RDATA_O[1:0] <= standby_control_reg;
        default: RRESP_O <= gppc_pkg::RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_in_reset;
    $fell(input_enable_reg[0]) |=> !EXT_INT_O[0];
  endproperty
  a_in_reset: assert property (p_in_reset) else $error("disabled input not zero");
  property p_stop_off;
    (stop_mode && !standby_drive_enable && !EXCEPT_MASK[0] && !VALID_GATED_MASK[0]) |=> !PIN_OE_O[0];
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("pin drives in STOP with drive disabled");
  property p_stop_in;
    (stop_mode && !standby_drive_enable && !EXCEPT_MASK[0]) |=> !FUNC_IN_O[0];
  endproperty
  a_stop_in: assert property (p_stop_in) else $error("input live in STOP with drive disabled");
  property p_stop_keep;
    (stop_mode && standby_drive_enable && input_enable_reg[0]) |=> FUNC_IN_O[0] == $past(pin_level[0]);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("input lost in STOP with drive enabled");
  property p_od;
    (|(open_drain_reg & drv_val)) |=> (PIN_OE_O & $past(open_drain_reg) & $past(drv_val)) == '0;
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin drives high");
  property p_pp;
    (!stop_mode && !open_drain_reg[0] && !function_select_reg1[0] && !function_select_reg2[0] && output_enable_reg[0])
      |=> PIN_OE_O[0] && PIN_O[0] == $past(pin_data_reg[0]);
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull pin not driven from data");
  property p_pull;
    1'b1 |=> PULLUP_O == $past(pullup_enable_reg) && PULLDOWN_O == $past(pulldown_enable_reg);
  endproperty
  a_pull: assert property (p_pull) else $error("pull controls do not follow registers");
  property p_run_int;
    (!stop_mode && input_enable_reg[0] && pin_level[0]) |=> EXT_INT_O[0];
  endproperty
  a_run_int: assert property (p_run_int) else $error("interrupt input blocked outside STOP");
  property p_bresp;
    (aw_held && w_held) |=> BVALID_O;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response missing");
  c_write: cover property (BVALID_O && BREADY_I);
  c_read: cover property (RVALID_O && RREADY_I);
  c_stop: cover property (stop_mode && !standby_drive_enable);
  c_func: cover property (function_select_reg1[0] && PIN_OE_O[0]);
endmodule

/* test/gppc_board.sv */
// Board model for the port pins: resolves each pin from port drive, outside drivers and pulls.
// Assumes the system clock; a pin nobody drives or pulls toggles every cycle.
`timescale 1ns/1ps
module gppc_board (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Port side
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] pulldown_i,
  // Outside drivers
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  // Resolved pin levels
  output logic [7:0] pin_i_o
);
  logic [7:0] float_lvl;
  // Floating pins show the inverse of their last level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      float_lvl <= 8'h00;
    else
      float_lvl <= ~pin_i_o;
  end
  always_comb
  begin
    for (int b = 0; b < 8; b++)
    begin
      if (pin_oe_i[b])
        pin_i_o[b] = pin_o_i[b];
      else if (ext_en_i[b])
        pin_i_o[b] = ext_val_i[b];
      else if (pullup_i[b])
        pin_i_o[b] = 1'b1;
      else if (pulldown_i[b])
        pin_i_o[b] = 1'b0;
      else
        pin_i_o[b] = float_lvl[b];
    end
  end
endmodule

/* test/gppc_port_tb.sv */
// Testbench for the port pin block: register tests over AXI4-Lite and pin checks.
// Assumes the board model in gppc_board and the design's default filter settings.
`timescale 1ns/1ps
module gppc_port_tb;
  logic clk, rst;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0] pin_in, pin_out, pin_oe, pu, pd, func_in, ext_int;
  logic [7:0] f1_out, f1_oe, f2_out, f2_oe, f_valid, ext_en, ext_val;
  int errors = 0;
  int cmp_count = 0;
  logic seen_pulse;
  gppc_port #(.WIDTH(8), .FILTER_MASK(8'hff), .EXCEPT_MASK(8'h40), .VALID_GATED_MASK(8'h80)) dut_u (
    .SYS_CLK_I(clk), .RST_I(rst),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(rvalid), .RREADY_I(rready), .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_O(pin_oe),
    .PULLUP_O(pu), .PULLDOWN_O(pd), .FUNC1_OUT_I(f1_out), .FUNC1_OE_I(f1_oe), .FUNC2_OUT_I(f2_out),
    .FUNC2_OE_I(f2_oe), .FUNC_VALID_I(f_valid), .FUNC_IN_O(func_in), .EXT_INT_O(ext_int));
  gppc_board board_u (.clk_i(clk), .rst_i(rst), .pin_o_i(pin_out), .pin_oe_i(pin_oe), .pullup_i(pu),
    .pulldown_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_i_o(pin_in));
  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, aw_done, w_done, b_ok;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(negedge clk);
      aw_ok = awvalid && (awready === 1'b1);
      w_ok = wvalid && (wready === 1'b1);
      @(posedge clk);
      if (aw_ok)
      begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_ok)
      begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!b_ok)
    begin
      @(negedge clk);
      b_ok = (bvalid === 1'b1);
      resp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok)
    begin
      @(negedge clk);
      ok = (arready === 1'b1);
      @(posedge clk);
    end
    arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge clk);
      ok = (rvalid === 1'b1);
      rd = rdata;
      resp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {f1_out, f1_oe, f2_out, f2_oe, f_valid, ext_en, ext_val} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    check({pin_oe, pu, pd, func_in}, 32'h0, "pins after reset");
    check({16'h0, pin_out, ext_int}, 32'h0, "drive and interrupt after reset");
    for (int i = 0; i <= 32; i += 4)
    begin
      rdx(i[7:0]);
      check(rd, 32'h0, "reset value");
    end
    rdx(8'h24);
    check({30'h0, resp}, {30'h0, gppc_pkg::RESP_SLVERR}, "unmapped read response");
    wr(8'h24, 32'h1);
    check({30'h0, resp}, {30'h0, gppc_pkg::RESP_SLVERR}, "unmapped write response");
    wr(gppc_pkg::OFS_PULLUP, 32'ha5);
    wr(gppc_pkg::OFS_PULLDOWN, 32'h5a);
    check({30'h0, resp}, {30'h0, gppc_pkg::RESP_OKAY}, "mapped write response");
    settle(2);
    check({16'h0, pu, pd}, 32'ha55a, "pull outputs");
    rdx(gppc_pkg::OFS_PULLUP);
    check(rd, 32'ha5, "pull-up readback");
    rdx(gppc_pkg::OFS_PULLDOWN);
    check(rd, 32'h5a, "pull-down readback");
    wr(gppc_pkg::OFS_PULLUP, 32'h0);
    wr(gppc_pkg::OFS_PULLDOWN, 32'h0);
    wr(gppc_pkg::OFS_PIN_DATA, 32'h3c);
    wr(gppc_pkg::OFS_OUTPUT_ENABLE, 32'hff);
    settle(2);
    check({16'h0, pin_out, pin_oe}, 32'h3cff, "push-pull drive");
    check({24'h0, func_in}, 32'h0, "input still disabled");
    wr(gppc_pkg::OFS_INPUT_ENABLE, 32'hff);
    settle(15);
    rdx(gppc_pkg::OFS_PIN_DATA);
    check(rd, 32'h3c, "pin data read");
    check({16'h0, func_in, ext_int}, 32'h3c3c, "input path and interrupt");
    wr(gppc_pkg::OFS_OPEN_DRAIN, 32'hff);
    settle(2);
    check({24'h0, pin_oe}, 32'hc3, "open drain drops high drive");
    wr(gppc_pkg::OFS_OPEN_DRAIN, 32'h0);
    f1_out <= 8'h05;
    f1_oe <= 8'hff;
    f2_out <= 8'ha0;
    f2_oe <= 8'h0f;
    wr(gppc_pkg::OFS_FUNC_SEL1, 32'h0f);
    wr(gppc_pkg::OFS_FUNC_SEL2, 32'hf0);
    settle(2);
    check({16'h0, pin_out, pin_oe}, 32'ha50f, "function routing");
    rdx(gppc_pkg::OFS_FUNC_SEL2);
    check(rd, 32'hf0, "function select readback");
    wr(gppc_pkg::OFS_FUNC_SEL1, 32'h0);
    wr(gppc_pkg::OFS_FUNC_SEL2, 32'h0);
    wr(gppc_pkg::OFS_PIN_DATA, 32'h55);
    wr(gppc_pkg::OFS_STANDBY_CTRL, 32'h3);
    settle(15);
    check({16'h0, pin_oe, func_in}, 32'h7f55, "stop with drive enabled");
    rdx(gppc_pkg::OFS_STANDBY_CTRL);
    check(rd, 32'h3, "standby control readback");
    f_valid <= 8'h80;
    wr(gppc_pkg::OFS_STANDBY_CTRL, 32'h1);
    settle(15);
    check({16'h0, pin_oe, func_in & 8'h7f}, 32'hc040, "stop with drive disabled");
    @(posedge clk);
    f_valid <= 8'h00;
    settle(3);
    check({24'h0, pin_oe}, 32'h40, "valid-gated pin released");
    wr(gppc_pkg::OFS_STANDBY_CTRL, 32'h0);
    wr(gppc_pkg::OFS_OUTPUT_ENABLE, 32'h0);
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    settle(15);
    seen_pulse = 1'b0;
    @(posedge clk);
    ext_val <= 8'h01;
    @(posedge clk);
    ext_val <= 8'h00;
    repeat (15)
    begin
      @(negedge clk);
      seen_pulse = seen_pulse | (func_in[0] === 1'b1);
    end
    check({31'h0, seen_pulse}, 32'h0, "short pulse rejected");
    @(posedge clk);
    ext_val <= 8'h01;
    settle(15);
    check({24'h0, func_in}, 32'h01, "long level passed");
    @(posedge clk);
    ext_val <= 8'hff;
    wr(gppc_pkg::OFS_INPUT_ENABLE, 32'h0);
    settle(4);
    rdx(gppc_pkg::OFS_PIN_DATA);
    check({16'h0, func_in, rd[7:0]}, 32'h0, "disabled input is quiet");
    conclude();
  end
endmodule
